// file: inc/vlc_pkg.sv
// Package for the voltage ladder control block: offsets, fields, resets, carriers
package vlc_pkg;
  // Register byte offsets
  localparam logic [11:0] VLC_CTRL_OFS = 12'h000;
  localparam logic [11:0] VLC_AUX_OFS = 12'h004;
  localparam logic [11:0] VLC_STAT_OFS = 12'h008;
  // Field positions in the control register
  localparam int VLC_POWER_BIT = 7;
  localparam int VLC_PIN_BIT = 6;
  localparam int VLC_RANGE_BIT = 5;
  localparam int VLC_SOURCE_BIT = 4;
  localparam int VLC_TAP_LSB = 0;
  localparam int VLC_TAP_W = 4;
  // Field positions in the aux register
  localparam int VLC_DIR_BIT = 0;
  localparam int VLC_MODE_LSB = 1;
  localparam int VLC_MODE_W = 3;
  // Values after reset
  localparam logic [7:0] VLC_CTRL_RST = 8'h00;
  localparam logic [2:0] VLC_MODE_RST = 3'h7;
  localparam logic VLC_DIR_RST = 1'b1;
  // Comparator mode that routes the ladder in
  localparam logic [2:0] VLC_MODE_MUX4 = 3'h6;
  // Ladder step divisors, scaled by 96 so both ranges are integers
  localparam int VLC_DIV_LOW = 24;
  localparam int VLC_DIV_HIGH = 32;
  localparam int VLC_SCALE = 96;
  localparam logic [7:0] VLC_LOW_STEP = 8'(VLC_SCALE / VLC_DIV_LOW);
  localparam logic [7:0] VLC_HIGH_STEP = 8'(VLC_SCALE / VLC_DIV_HIGH);
  localparam logic [7:0] VLC_HIGH_BASE = 8'(VLC_SCALE / 4);
  // AXI responses
  localparam logic [1:0] VLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VLC_RESP_SLVERR = 2'h2;

  // Control register layout
  typedef struct packed {
    logic power_on;
    logic pin_drive;
    logic range_sel;
    logic source_sel;
    logic [3:0] tap;
  } vlc_ctrl_t;

  // Analog-side control bundle
  typedef struct packed {
    logic ladder_power_on;
    logic level_pin_drive;
    logic step_range_select;
    logic supply_source_select;
    logic [3:0] tap_select;
    logic [7:0] level_code;
    logic comp_ref_route;
    logic pin_dir_eff;
  } vlc_analog_t;
endpackage

// file: hw/vlc_level_calc.sv
// Nominal level code for the ladder, in 96ths of the supply span
`timescale 1ns/1ps
module vlc_level_calc (
  input wire vlc_pkg::vlc_ctrl_t ctrl_in, // Stored control fields
  output logic [7:0] level_out // Level in 96ths of span, zero when off
);
  import vlc_pkg::*;
  logic [7:0] tap8;
  assign tap8 = {4'h0, ctrl_in.tap};
  // Both ranges share one scale so the code is exact
  always_comb begin
    if (!ctrl_in.power_on) begin
      level_out = 8'h00;
    end else if (ctrl_in.range_sel) begin
      level_out = 8'(tap8 * VLC_LOW_STEP);
    end else begin
      level_out = 8'(VLC_HIGH_BASE + tap8 * VLC_HIGH_STEP);
    end
  end
endmodule

// file: hw/vlc_top.sv
// Voltage ladder control: AXI4-Lite register slave and analog-side controls
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module vlc_top (
  input wire logic clk_sys_in, // 125 MHz system clock
  input wire logic reset_in, // Synchronous active-high device reset
  input wire logic sleep_wake_in, // Wake event pulse, register untouched
  input wire logic [11:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [11:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  output vlc_pkg::vlc_analog_t analog_out // Controls to ladder and pin mux
);
  import vlc_pkg::*;

  // Register map, one 32-bit word each, only byte 0 carries bits
  //   Control word: power, pin drive, range, source, four tap bits
  //   Aux word: port direction in bit 0, comparator mode above it
  //   Status word: read-only nominal level code of the ladder
  // Unmapped words answer SLVERR and change nothing
  // A write with strobe 0 clear answers OKAY and changes nothing
  // Upper bytes of write data are dropped and read back as zero

  // Stored settings; only reset or a bus write moves them
  vlc_ctrl_t voltage_ladder_control;
  logic port_direction_bits;
  logic [2:0] comparator_mode_field;
  // Holding registers for the two write halves
  logic [31:0] aw_addr_q;
  logic aw_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held;
  logic [7:0] level_code;
  logic [11:0] aw_addr_lat;

  assign aw_addr_lat = aw_addr_q[11:0];

  // Write timing, counted from the edge that first sees a valid
  //   first edge raises awready or wready for one cycle
  //   second edge takes that half into its holding register
  //   edge after both are held commits the word and raises bvalid
  //   bvalid then stands until the edge that sees bready
  // Ready is a registered pulse, so each channel costs an idle cycle;
  // traded for clean timing with no path from valid to ready
  // A new half is refused while one is held or the response waits,
  // so only one write is ever in flight
  // Address and data are caught independently, either order
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      aw_held <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= 1'b0;
      if (s_axi_awvalid_in && !aw_held && !s_axi_awready_out && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr_q <= {20'h00000, s_axi_awaddr_in};
      end else if (aw_held && w_held) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= 1'b0;
      if (s_axi_wvalid_in && !w_held && !s_axi_wready_out && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end else if (aw_held && w_held) begin
        w_held <= 1'b0;
      end
    end
  end

  // Commit the write once both halves are held; the answer follows
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      voltage_ladder_control <= VLC_CTRL_RST;
      port_direction_bits <= VLC_DIR_RST;
      comparator_mode_field <= VLC_MODE_RST;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= VLC_RESP_OKAY;
    end else begin
      // Wake input is left unused on purpose: settings must survive
      // a wake, and software powers the ladder down before sleep
      // Only device reset returns the ladder to off, pin free, high range
      // Wake from sleep has no path here, so settings persist
      if (aw_held && w_held && !s_axi_bvalid_out) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= VLC_RESP_OKAY;
        if (aw_addr_lat[11:2] == VLC_CTRL_OFS[11:2]) begin
          if (w_strb_q[0]) begin
            voltage_ladder_control <= w_data_q[7:0];
          end
        end else if (aw_addr_lat[11:2] == VLC_AUX_OFS[11:2]) begin
          if (w_strb_q[0]) begin
            port_direction_bits <= w_data_q[VLC_DIR_BIT];
            comparator_mode_field <= w_data_q[VLC_MODE_LSB +: VLC_MODE_W];
          end
        end else begin
          s_axi_bresp_out <= VLC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read timing: arready one cycle after arvalid, data one cycle after
  // the handshake; rvalid and data stand until rready is seen
  // A new read is refused while rvalid is still up
  // Read channel: one cycle to accept, data the next
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= VLC_RESP_OKAY;
    end else begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= VLC_RESP_OKAY;
        unique case (s_axi_araddr_in[11:2])
          VLC_CTRL_OFS[11:2]: s_axi_rdata_out <= {24'h000000, voltage_ladder_control};
          VLC_AUX_OFS[11:2]: s_axi_rdata_out <= {28'h0000000, comparator_mode_field,
                                                 port_direction_bits};
          VLC_STAT_OFS[11:2]: s_axi_rdata_out <= {24'h000000, level_code};
          // Unmapped reads return zero data with an error code
          default: begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= VLC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Level code is in 96ths of the span, so both step sizes are whole
  // Code is zero while powered down, and also when powered in range one at tap 0
  // Nominal level for the selected range and tap
  vlc_level_calc u_level (
    .ctrl_in(voltage_ladder_control),
    .level_out(level_code)
  );

  // Analog controls trail the register by one edge; the ladder needs
  // its own settling time anyway, so the extra cycle costs nothing
  // Comparator mode only steers the route bit, never the ladder power
  // Registered analog controls; ladder does not depend on comparator mode
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      analog_out <= '0;
      analog_out.pin_dir_eff <= VLC_DIR_RST;
    end else begin
      analog_out.ladder_power_on <= voltage_ladder_control.power_on;
      analog_out.level_pin_drive <= voltage_ladder_control.pin_drive;
      analog_out.step_range_select <= voltage_ladder_control.range_sel;
      analog_out.supply_source_select <= voltage_ladder_control.source_sel;
      analog_out.tap_select <= voltage_ladder_control.tap;
      analog_out.level_code <= level_code;
      // Only the four-input muxed mode feeds the ladder to both plus inputs
      analog_out.comp_ref_route <= (comparator_mode_field == VLC_MODE_MUX4);
      // Pin drive forces the pin away from digital direction control
      analog_out.pin_dir_eff <= voltage_ladder_control.pin_drive ? 1'b1
                                                                 : port_direction_bits;
    end
  end
endmodule

// file: verif/vlc_checker.sv
// Port-level assertions for the ladder control block
`timescale 1ns/1ps
module vlc_checker import vlc_pkg::*; (
  input wire logic clk_sys_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic s_axi_awvalid_in, // Aw valid
  input wire logic s_axi_awready_out, // Aw ready
  input wire logic s_axi_bvalid_out, // B valid
  input wire logic s_axi_bready_in, // B ready
  input wire logic [1:0] s_axi_bresp_out, // B resp
  input wire logic s_axi_arvalid_in, // Ar valid
  input wire logic s_axi_arready_out, // Ar ready
  input wire logic s_axi_rvalid_out, // R valid
  input wire vlc_analog_t analog_out // Ladder controls
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Handshakes that start each answer
  sequence aw_take; s_axi_awvalid_in && s_axi_awready_out; endsequence
  sequence ar_take; s_axi_arvalid_in && s_axi_arready_out; endsequence
  off_level_a: assert property (!analog_out.ladder_power_on |->
    analog_out.level_code == 8'h00) else $error("Level while powered off");
  high_step_a: assert property (analog_out.ladder_power_on &&
    analog_out.step_range_select |-> analog_out.level_code == {2'h0, analog_out.tap_select, 2'h0})
    else $error("Wrong level in range one");
  low_step_a: assert property (analog_out.ladder_power_on &&
    !analog_out.step_range_select |-> analog_out.level_code == 8'h18 +
    8'(analog_out.tap_select) * 8'h03) else $error("Wrong level in range zero");
  pin_over_a: assert property (analog_out.level_pin_drive |->
    analog_out.pin_dir_eff) else $error("Pin drive lost to direction bit");
  reset_clr_a: assert property ($past(reset_in) |->
    analog_out == 18'h00001) else $error("Controls not cleared by reset");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("Write answer dropped");
  w_answer_a: assert property (aw_take |-> ##[1:4] s_axi_bvalid_out)
    else $error("Write answer late");
  r_answer_a: assert property (ar_take |=> s_axi_rvalid_out)
    else $error("Read answer late");
  // Only a completed write may move the controls; a wake pulse must not
  ctrl_static_a: assert property (!$past(s_axi_bvalid_out) |->
    $stable(analog_out[17:10])) else $error("Controls moved without a write");
endmodule
bind vlc_top vlc_checker chk (.*);

// file: verif/vlc_ladder_model.sv
// Behavioural ladder: settles to the commanded level after a delay
`timescale 1ns/1ps
module vlc_ladder_model import vlc_pkg::*; #(parameter int SETTLE = 3) (
  input wire logic clk_sys_in, // Clock
  input wire vlc_analog_t analog_out, // Commands from the block
  output logic settled_out, // Level usable
  output logic [7:0] level_seen_out // Level at comparators
);
  int cnt = 0;
  logic [7:0] last = 8'h00;
  // Any new level restarts the wait; output is garbage until settled
  always @(posedge clk_sys_in) begin
    if (analog_out.level_code != last) cnt <= 0;
    else if (cnt < SETTLE) cnt <= cnt + 1;
    last <= analog_out.level_code;
  end
  assign settled_out = (cnt == SETTLE);
  assign level_seen_out = settled_out ? last : ~last;
endmodule

// file: verif/vlc_top_tb.sv
// Self-checking bench for the ladder control block
`timescale 1ns/1ps
module vlc_top_tb;
  import vlc_pkg::*;
  `define CK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  logic clk_sys_in = 1'b0, reset_in = 1'b1, sleep_wake_in = 1'b0;
  logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, rd;
  logic [3:0] s_axi_wstrb_in = '0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, settled_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic [7:0] level_seen_out;
  vlc_analog_t analog_out;
  int fail_count = 0, compares = 0, cyc = 0;
  logic late_bready = 1'b0;
  typedef struct packed { logic [7:0] ctrl; logic [7:0] lvl; } vlc_row_t;
  vlc_row_t rows [8] = '{16'h8018, 16'h9f45, 16'hbf3c, 16'ha000, 16'h0000, 16'hb104,
    16'h7f00, 16'hd527};
  vlc_top dut (.*);
  vlc_ladder_model #(.SETTLE(3)) ladder (.*);
  always #4 clk_sys_in = ~clk_sys_in;
  // Each channel held until its own ready; idle edge first avoids double drive
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= !late_bready;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    // Late mode: take the response one edge after it appears
    if (late_bready) begin
      s_axi_bready_in <= 1'b1;
      @(posedge clk_sys_in);
    end
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_reg(VLC_CTRL_OFS);
    `CK("ctrl reset", 32'h00000000, rd)
    // Mode 6 and direction 0, so the pin only turns on through drive
    wr(VLC_AUX_OFS, 8'h0c, 4'h1);
    foreach (rows[i]) begin
      wr(VLC_CTRL_OFS, rows[i].ctrl, 4'hf);
      `CK("wr resp", VLC_RESP_OKAY, rsp)
      rd_reg(VLC_CTRL_OFS);
      `CK("rd resp", VLC_RESP_OKAY, rsp)
      `CK("ctrl", {24'h000000, rows[i].ctrl}, rd)
      `CK("fields", rows[i].ctrl, analog_out[17:10])
      `CK("level", rows[i].lvl, analog_out.level_code)
      `CK("dir", rows[i].ctrl[6], analog_out.pin_dir_eff)
      `CK("route", 1'b1, analog_out.comp_ref_route)
      rd_reg(VLC_STAT_OFS);
      `CK("status", {24'h000000, rows[i].lvl}, rd)
      `CK("seen", rows[i].lvl, level_seen_out)
      `CK("settled", 1'b1, settled_out)
    end
    // Comparators off, then a strobeless write and unmapped places
    wr(VLC_AUX_OFS, 8'h0e, 4'h1);
    rd_reg(VLC_AUX_OFS);
    `CK("aux", 32'h0000000e, rd)
    `CK("route off", 1'b0, analog_out.comp_ref_route)
    `CK("level alone", 8'h27, analog_out.level_code)
    late_bready = 1'b1;
    wr(VLC_CTRL_OFS, 8'h00, 4'h0);
    late_bready = 1'b0;
    `CK("no strobe", VLC_RESP_OKAY, rsp)
    wr(12'h010, 8'hff, 4'hf);
    `CK("bad wr", VLC_RESP_SLVERR, rsp)
    rd_reg(12'h00c);
    `CK("bad rd", VLC_RESP_SLVERR, rsp)
    rd_reg(VLC_CTRL_OFS);
    `CK("kept", 32'h000000d5, rd)
    wr(VLC_CTRL_OFS, 8'h1a, 4'h1);
    sleep_wake_in <= 1'b1;
    @(posedge clk_sys_in);
    sleep_wake_in <= 1'b0;
    rd_reg(VLC_CTRL_OFS);
    `CK("wake", 32'h0000001a, rd)
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_reg(VLC_CTRL_OFS);
    `CK("reset ctrl", 32'h00000000, rd)
    `CK("reset out", 18'h00001, analog_out)
    wrap_up;
  end
endmodule
